/* File: shared/pps_regs.svh */
// register offsets, field positions, reset values and sizes of the pin select
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH

// byte offsets of the selector and status registers on the register bus
`define PPS_OFF_CAP_LO      32'h0000_0000
`define PPS_OFF_CAP_HI      32'h0000_0004
`define PPS_OFF_FAULT       32'h0000_0008
`define PPS_OFF_TCLK        32'h0000_000c
`define PPS_OFF_TAMPER      32'h0000_0010
`define PPS_OFF_CAP_FIVE    32'h0000_0014
`define PPS_OFF_STATUS      32'h0000_0018

// register index taken from a byte address, and its place in the address
`define PPS_IDX_W           3
`define PPS_IDX_LSB         2
`define PPS_IDX_NONE        3'h7

// selector field layout inside a register
`define PPS_SEL_W           6
`define PPS_LO_LSB          0
`define PPS_HI_LSB          8
`define PPS_SEL_RST         6'h3f

// number of remappable pins and the level of an unconnected input
`define PPS_NUM_PINS        48
`define PPS_INACTIVE        1'b0

// number of routed peripheral inputs
`define PPS_NSEL            11

`endif

/* File: shared/pps_pkg.sv */
// types shared by the pin select modules
package pps_pkg;
   typedef logic [5:0]  pps_sel_t;
   typedef logic [2:0]  pps_idx_t;
   typedef logic [31:0] pps_word_t;

   // routed peripheral inputs, also the bit order of the status register
   typedef enum int {
      PPS_CAP_ONE,
      PPS_CAP_TWO,
      PPS_CAP_THREE,
      PPS_CAP_FOUR,
      PPS_CAP_FIVE,
      PPS_FAULT_A,
      PPS_FAULT_B,
      PPS_TCLK_A,
      PPS_TCLK_B,
      PPS_TAMPER,
      PPS_REFCLK
   } pps_periph_t;

   // bus slave states
   typedef enum logic {
      PPS_ST_IDLE,
      PPS_ST_RD
   } pps_state_t;
endpackage

/* File: shared/pps_if.sv */
// carriers between the pin select register file, bus slave and multiplexer
`timescale 1ns/1ps
`include "pps_regs.svh"

interface pps_acc_if;
   logic                wr_en;
   pps_pkg::pps_word_t  wr_data;
   pps_pkg::pps_word_t  addr;
   pps_pkg::pps_word_t  rd_data;

   modport slave (output wr_en, output wr_data, output addr,
                  input rd_data);
   modport regs  (input wr_en, input wr_data, input addr,
                  output rd_data);
endinterface

interface pps_sel_if;
   pps_pkg::pps_sel_t      sel [`PPS_NSEL];
   logic [`PPS_NSEL-1:0]   level;

   modport regs (output sel, input level);
   modport mux  (input sel, output level);
endinterface

/* File: hw/pps_ahb_slave.sv */
// ahb-lite slave front end for the pin select registers
`timescale 1ns/1ps
`include "pps_regs.svh"

module pps_ahb_slave (
   // clock and reset
   input  wire logic                core_clk_i,
   input  wire logic                rst_n_i,
   // ahb-lite slave side
   input  wire logic                hsel_i,
   input  wire pps_pkg::pps_word_t  haddr_i,
   input  wire logic [1:0]          htrans_i,
   input  wire logic                hwrite_i,
   input  wire pps_pkg::pps_word_t  hwdata_i,
   input  wire logic                hready_i,
   output      logic                hreadyout_o,
   output      logic                hresp_o,
   output      pps_pkg::pps_word_t  hrdata_o,
   // register file access
   pps_acc_if.slave                 acc
);
   import pps_pkg::*;

   pps_state_t  st_q;
   logic        hready_q;
   logic        wr_pend_q;
   pps_word_t   addr_q;
   pps_word_t   hrdata_q;
   logic        take;

   // nonseq or seq address phase accepted while the bus is ready
   assign take = hsel_i & htrans_i[1] & hready_i;

   // a read costs one wait state so read data always come from a flop
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q     <= PPS_ST_IDLE;
         hready_q <= 1'b1;
      end else begin
         unique case (st_q)
            PPS_ST_IDLE: begin
               if (take && !hwrite_i) begin
                  st_q     <= PPS_ST_RD;
                  hready_q <= 1'b0;
               end
            end
            PPS_ST_RD: begin
               st_q     <= PPS_ST_IDLE;
               hready_q <= 1'b1;
            end
         endcase
      end
   end

   // address and write flag of the accepted transfer
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_q    <= 32'h0000_0000;
         wr_pend_q <= 1'b0;
      end else begin
         wr_pend_q <= take & hwrite_i;
         if (take) begin
            addr_q <= haddr_i;
         end
      end
   end

   // read data sampled in the wait state, after any earlier write landed
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hrdata_q <= 32'h0000_0000;
      end else if (st_q == PPS_ST_RD) begin
         hrdata_q <= acc.rd_data;
      end
   end

   // write commits at the end of its data phase, when hwdata stands
   assign acc.wr_en   = wr_pend_q;
   assign acc.wr_data = hwdata_i;
   assign acc.addr    = addr_q;

   assign hreadyout_o = hready_q;
   assign hresp_o     = 1'b0;  // every answer is okay
   assign hrdata_o    = hrdata_q;
endmodule

/* File: hw/pps_pin_mux.sv */
// registered input multiplexers from remappable pins to peripheral inputs
`timescale 1ns/1ps
`include "pps_regs.svh"

module pps_pin_mux (
   // clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_n_i,
   // remappable pins
   input  wire logic [`PPS_NUM_PINS-1:0] pins_i,
   // selectors in, routed levels out
   pps_sel_if.mux                        sel_if
);
   import pps_pkg::*;

   logic [`PPS_NSEL-1:0] level_q;

   // index into the pins; codes past the last pin give the idle level
   function automatic logic pick(input logic [`PPS_NUM_PINS-1:0] p,
                                 input pps_sel_t s);
      logic r;
      r = `PPS_INACTIVE;
      if (int'(s) < `PPS_NUM_PINS) begin
         r = p[s];
      end
      return r;
   endfunction

   // one flop per routed input keeps the output glitch free on reselect
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_q <= '0;
      end else begin
         for (int k = 0; k < `PPS_NSEL; k++) begin
            level_q[k] <= pick(pins_i, sel_if.sel[k]);  // [R14]
         end
      end
   end

   assign sel_if.level = level_q;
endmodule

/* File: hw/pps_top.sv */
// input pin select: selector registers and routing to peripheral inputs
//
// Overview of operation
// [R01] capture one follows first register low selector
// [R02] capture two follows first register high selector
// [R03] capture three follows second register low selector
// [R04] capture four follows second register high selector
// [R05] capture five follows own low selector
// [R06] fault A input follows fault low selector
// [R07] fault B input follows fault high selector
// [R08] timer clock A follows clock low selector
// [R09] timer clock B follows clock high selector
// [R10] tamper input follows tamper high selector
// [R11] reference clock follows tamper low selector
// [R12] selectors read/write, reset to all ones
// [R13] unused bits ignore writes, read zero
// [R14] out-of-range selector gives inactive level
// [R15] new selector acts the cycle after write
`timescale 1ns/1ps
`include "pps_regs.svh"

module pps_top (
   // clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_n_i,
   // ahb-lite register bus
   input  wire logic                     hsel_i,
   input  wire pps_pkg::pps_word_t       haddr_i,
   input  wire logic [1:0]               htrans_i,
   input  wire logic                     hwrite_i,
   input  wire logic [2:0]               hsize_i,
   input  wire pps_pkg::pps_word_t       hwdata_i,
   input  wire logic                     hready_i,
   output      logic                     hreadyout_o,
   output      logic                     hresp_o,
   output      pps_pkg::pps_word_t       hrdata_o,
   // remappable device pins
   input  wire logic [`PPS_NUM_PINS-1:0] remappable_io_pin_i,
   // capture inputs of the capture/compare modules
   output      logic                     capture_one_input_o,
   output      logic                     capture_two_input_o,
   output      logic                     capture_three_input_o,
   output      logic                     capture_four_input_o,
   output      logic                     capture_five_input_o,
   // output compare fault inputs
   output      logic                     compare_fault_a_input_o,
   output      logic                     compare_fault_b_input_o,
   // external clocks of the capture/compare timers
   output      logic                     timer_ext_clock_a_o,
   output      logic                     timer_ext_clock_b_o,
   // tamper and reference clock inputs
   output      logic                     tamper_detect_input_o,
   output      logic                     reference_clock_input_o
);
   import pps_pkg::*;

   pps_acc_if acc ();
   pps_sel_if sel_if ();

   // selectors, bus index and read image
   pps_sel_t             sel_q   [`PPS_NSEL];
   pps_idx_t             acc_idx;
   pps_word_t            rd_word;
   // write strobe and incoming field of each selector
   logic [`PPS_NSEL-1:0] sel_we;
   pps_sel_t             sel_new [`PPS_NSEL];

   // byte address to register index; anything off the map is none
   function automatic pps_idx_t reg_index(input pps_word_t a);
      pps_idx_t r;
      r = `PPS_IDX_NONE;
      unique case (a)
         `PPS_OFF_CAP_LO:   r = pps_idx_t'(`PPS_OFF_CAP_LO >> 2);
         `PPS_OFF_CAP_HI:   r = pps_idx_t'(`PPS_OFF_CAP_HI >> 2);
         `PPS_OFF_FAULT:    r = pps_idx_t'(`PPS_OFF_FAULT >> 2);
         `PPS_OFF_TCLK:     r = pps_idx_t'(`PPS_OFF_TCLK >> 2);
         `PPS_OFF_TAMPER:   r = pps_idx_t'(`PPS_OFF_TAMPER >> 2);
         `PPS_OFF_CAP_FIVE: r = pps_idx_t'(`PPS_OFF_CAP_FIVE >> 2);
         `PPS_OFF_STATUS:   r = pps_idx_t'(`PPS_OFF_STATUS >> 2);
         default:           r = `PPS_IDX_NONE;
      endcase
      return r;
   endfunction

   // register that holds a given selector
   function automatic pps_idx_t sel_reg(input int k);
      pps_word_t off;
      off = `PPS_OFF_CAP_LO;
      unique case (k)
         PPS_CAP_ONE, PPS_CAP_TWO:     off = `PPS_OFF_CAP_LO;    // [R01] [R02]
         PPS_CAP_THREE, PPS_CAP_FOUR:  off = `PPS_OFF_CAP_HI;    // [R03] [R04]
         PPS_CAP_FIVE:                 off = `PPS_OFF_CAP_FIVE;  // [R05]
         PPS_FAULT_A, PPS_FAULT_B:     off = `PPS_OFF_FAULT;     // [R06] [R07]
         PPS_TCLK_A, PPS_TCLK_B:       off = `PPS_OFF_TCLK;      // [R08] [R09]
         PPS_TAMPER, PPS_REFCLK:       off = `PPS_OFF_TAMPER;    // [R10] [R11]
         default:                      off = `PPS_OFF_STATUS;
      endcase
      return reg_index(off);
   endfunction

   // lowest bit of a selector within its register
   function automatic int sel_lsb(input int k);
      int r;
      r = `PPS_LO_LSB;
      unique case (k)
         PPS_CAP_TWO, PPS_CAP_FOUR, PPS_FAULT_B, PPS_TCLK_B,
         PPS_TAMPER:  r = `PPS_HI_LSB;  // [R02] [R04] [R07] [R09] [R10]
         default:     r = `PPS_LO_LSB;  // [R01] [R03] [R05] [R06] [R08] [R11]
      endcase
      return r;
   endfunction

   // bus front end; a read stalls one cycle, a write none
   pps_ahb_slave u_slave (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .hsel_i      (hsel_i),
      .haddr_i     (haddr_i),
      .htrans_i    (htrans_i),
      .hwrite_i    (hwrite_i),
      .hwdata_i    (hwdata_i),
      .hready_i    (hready_i),
      .hreadyout_o (hreadyout_o),
      .hresp_o     (hresp_o),
      .hrdata_o    (hrdata_o),
      .acc         (acc)
   );

   // only whole words are expected; narrower sizes are treated as words
   assign acc_idx = reg_index(acc.addr);

   // write strobe and new field of each selector; bits 7-6, 15-14 and 31-16
   // have no storage, so writes to them fall away
   always_comb begin
      for (int k = 0; k < `PPS_NSEL; k++) begin
         sel_we[k]  = acc.wr_en && (acc_idx == sel_reg(k));
         sel_new[k] = acc.wr_data[sel_lsb(k) +: `PPS_SEL_W];  // [R13]
      end
   end

   // capture one: low field, first capture register
   // one process per selector, so a write touches its own field only
   // reset points past the last pin, so every input starts inactive
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q[PPS_CAP_ONE] <= `PPS_SEL_RST;  // [R12]
      end else if (sel_we[PPS_CAP_ONE]) begin
         sel_q[PPS_CAP_ONE] <= sel_new[PPS_CAP_ONE];  // [R01]
      end
   end

   // capture two: high field, first capture register
   // lands in the same write as capture one
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q[PPS_CAP_TWO] <= `PPS_SEL_RST;  // [R12]
      end else if (sel_we[PPS_CAP_TWO]) begin
         sel_q[PPS_CAP_TWO] <= sel_new[PPS_CAP_TWO];  // [R02]
      end
   end

   // capture three: low field, second capture register
   // a partial word write is not possible
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q[PPS_CAP_THREE] <= `PPS_SEL_RST;  // [R12]
      end else if (sel_we[PPS_CAP_THREE]) begin
         sel_q[PPS_CAP_THREE] <= sel_new[PPS_CAP_THREE];  // [R03]
      end
   end

   // capture four: high field, second capture register
   // lands in the same write as capture three
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q[PPS_CAP_FOUR] <= `PPS_SEL_RST;  // [R12]
      end else if (sel_we[PPS_CAP_FOUR]) begin
         sel_q[PPS_CAP_FOUR] <= sel_new[PPS_CAP_FOUR];  // [R04]
      end
   end

   // capture five: low field of its own register
   // the whole upper part of that register has no storage
   // and reads as zero
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q[PPS_CAP_FIVE] <= `PPS_SEL_RST;  // [R12]
      end else if (sel_we[PPS_CAP_FIVE]) begin
         sel_q[PPS_CAP_FIVE] <= sel_new[PPS_CAP_FIVE];  // [R05]
      end
   end

   // fault a: low field, fault register
   // kept inactive until software picks a pin
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q[PPS_FAULT_A] <= `PPS_SEL_RST;  // [R12]
      end else if (sel_we[PPS_FAULT_A]) begin
         sel_q[PPS_FAULT_A] <= sel_new[PPS_FAULT_A];  // [R06]
      end
   end

   // fault b: high field, fault register
   // lands in the same write as fault a
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q[PPS_FAULT_B] <= `PPS_SEL_RST;  // [R12]
      end else if (sel_we[PPS_FAULT_B]) begin
         sel_q[PPS_FAULT_B] <= sel_new[PPS_FAULT_B];  // [R07]
      end
   end

   // timer clock a: low field, clock register
   // a reselect may cut one clock pulse short
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q[PPS_TCLK_A] <= `PPS_SEL_RST;  // [R12]
      end else if (sel_we[PPS_TCLK_A]) begin
         sel_q[PPS_TCLK_A] <= sel_new[PPS_TCLK_A];  // [R08]
      end
   end

   // timer clock b: high field, clock register
   // lands in the same write as clock a
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q[PPS_TCLK_B] <= `PPS_SEL_RST;  // [R12]
      end else if (sel_we[PPS_TCLK_B]) begin
         sel_q[PPS_TCLK_B] <= sel_new[PPS_TCLK_B];  // [R09]
      end
   end

   // tamper: high field, tamper register
   // note the reversed order against the other pairs
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q[PPS_TAMPER] <= `PPS_SEL_RST;  // [R12]
      end else if (sel_we[PPS_TAMPER]) begin
         sel_q[PPS_TAMPER] <= sel_new[PPS_TAMPER];  // [R10]
      end
   end

   // reference clock: low field, tamper register
   // lands in the same write as tamper
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q[PPS_REFCLK] <= `PPS_SEL_RST;  // [R12]
      end else if (sel_we[PPS_REFCLK]) begin
         sel_q[PPS_REFCLK] <= sel_new[PPS_REFCLK];  // [R11]
      end
   end

   // read image: selectors and status levels in place, every other bit zero
   always_comb begin
      rd_word = '0;
      for (int k = 0; k < `PPS_NSEL; k++) begin
         if (acc_idx == sel_reg(k)) begin
            rd_word[sel_lsb(k) +: `PPS_SEL_W] = sel_q[k];  // [R12] [R13]
         end
      end
      // status shows the levels currently delivered to the peripherals
      if (acc_idx == reg_index(`PPS_OFF_STATUS)) begin
         rd_word[`PPS_NSEL-1:0] = sel_if.level;
      end
   end

   assign acc.rd_data = rd_word;

   // selectors go straight to the multiplexer, no shadow copy
   always_comb begin
      for (int k = 0; k < `PPS_NSEL; k++) begin
         sel_if.sel[k] = sel_q[k];  // [R15]
      end
   end

   // the routing flop adds one cycle of latency but no combinational path
   // from the pins to peripheral logic, which eases timing closure
   pps_pin_mux u_mux (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .pins_i     (remappable_io_pin_i),
      .sel_if     (sel_if)
   );

   // capture inputs
   assign capture_one_input_o     = sel_if.level[PPS_CAP_ONE];    // [R01]
   assign capture_two_input_o     = sel_if.level[PPS_CAP_TWO];    // [R02]
   assign capture_three_input_o   = sel_if.level[PPS_CAP_THREE];  // [R03]
   assign capture_four_input_o    = sel_if.level[PPS_CAP_FOUR];   // [R04]
   assign capture_five_input_o    = sel_if.level[PPS_CAP_FIVE];   // [R05]

   // fault inputs
   assign compare_fault_a_input_o = sel_if.level[PPS_FAULT_A];    // [R06]
   assign compare_fault_b_input_o = sel_if.level[PPS_FAULT_B];    // [R07]

   // timer clocks; these are sampled levels, not clock nets
   assign timer_ext_clock_a_o     = sel_if.level[PPS_TCLK_A];     // [R08]
   assign timer_ext_clock_b_o     = sel_if.level[PPS_TCLK_B];     // [R09]

   // tamper and reference clock
   assign tamper_detect_input_o   = sel_if.level[PPS_TAMPER];     // [R10]
   assign reference_clock_input_o = sel_if.level[PPS_REFCLK];     // [R11]
endmodule

/* File: tb/pps_pin_model.sv */
// model of the remappable device pins seen by the pin select
`timescale 1ns/1ps
`include "pps_regs.svh"

module pps_pin_model (
   // clock and wanted pin levels
   input  wire logic                     core_clk_i,
   input  wire logic [`PPS_NUM_PINS-1:0] pat_i,
   // remappable device pins
   output      logic [`PPS_NUM_PINS-1:0] pins_o
);
   // pads move just after an edge, so the design samples them cleanly
   always_ff @(posedge core_clk_i) begin
      pins_o <= pat_i;
   end
endmodule

/* File: tb/pps_top_chk.sv */
// assertions on the pin select top ports, bound into the design
`timescale 1ns/1ps
`include "pps_regs.svh"

module pps_top_chk (
   // clock and reset
   input wire logic                     core_clk_i,
   input wire logic                     rst_n_i,
   // register bus
   input wire logic                     hsel_i,
   input wire pps_pkg::pps_word_t       haddr_i,
   input wire logic [1:0]               htrans_i,
   input wire logic                     hwrite_i,
   input wire pps_pkg::pps_word_t       hwdata_i,
   input wire logic                     hready_i,
   input wire logic                     hreadyout_o,
   input wire logic                     hresp_o,
   // pins and routed inputs
   input wire logic [`PPS_NUM_PINS-1:0] remappable_io_pin_i,
   input wire logic                     capture_one_input_o,
   input wire logic                     capture_three_input_o,
   input wire logic                     capture_five_input_o,
   input wire logic                     compare_fault_a_input_o,
   input wire logic                     timer_ext_clock_a_o,
   input wire logic                     tamper_detect_input_o,
   input wire logic                     reference_clock_input_o
);
   import pps_pkg::*;
   // shadow index fed by each register's low and high field
   localparam int LO_MAP [6] = '{0, 2, 5, 7, 10, 4};
   localparam int HI_MAP [6] = '{1, 3, 6, 8, 9, 11};
   logic        wr_q;
   logic [2:0]  idx_q;
   pps_sel_t    sel_q [12];
   logic [10:0] exp_v;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   // remember a write address phase; exact word addresses only
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_q  <= 1'b0;
         idx_q <= 3'h0;
      end else if (hready_i) begin
         wr_q  <= hsel_i & htrans_i[1] & hwrite_i &
                  (haddr_i[31:5] == 27'h0) & (haddr_i[1:0] == 2'h0);
         idx_q <= haddr_i[4:2];
      end
   end

   // shadow selectors load as the write data phase completes
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int k = 0; k < 12; k++)
            sel_q[k] <= `PPS_SEL_RST;
      end else if (wr_q && hready_i && idx_q < 3'h6) begin
         sel_q[LO_MAP[idx_q]] <= hwdata_i[5:0];
         sel_q[HI_MAP[idx_q]] <= hwdata_i[13:8];
      end
   end

   // chosen pin level, or inactive past the last pin
   always_comb begin
      for (int k = 0; k < 11; k++)
         exp_v[k] = (sel_q[k] < `PPS_NUM_PINS) ?
                    remappable_io_pin_i[sel_q[k]] : `PPS_INACTIVE;
   end

   sequence s_rd_taken;
      hsel_i && htrans_i[1] && !hwrite_i && hready_i;
   endsequence
   sequence s_one_wait;
      !hreadyout_o ##1 hreadyout_o;
   endsequence

   a_read_one_wait:
      assert property (s_rd_taken |=> s_one_wait)
      else $error("read wait is not one cycle");
   a_resp_okay:
      assert property (hresp_o == 1'b0)
      else $error("response is not okay");
   a_cap_one_route:
      assert property (capture_one_input_o == $past(exp_v[0]))
      else $error("capture one level wrong");
   a_cap_three_route:
      assert property (capture_three_input_o == $past(exp_v[2]))
      else $error("capture three level wrong");
   a_cap_five_route:
      assert property (capture_five_input_o == $past(exp_v[4]))
      else $error("capture five level wrong");
   a_fault_a_route:
      assert property (compare_fault_a_input_o == $past(exp_v[5]))
      else $error("fault a level wrong");
   a_clock_a_route:
      assert property (timer_ext_clock_a_o == $past(exp_v[7]))
      else $error("clock a level wrong");
   a_tamper_route:
      assert property (tamper_detect_input_o == $past(exp_v[9]))
      else $error("tamper level wrong");
   a_refclk_route:
      assert property (reference_clock_input_o == $past(exp_v[10]))
      else $error("reference clock level wrong");
   a_bad_sel_idle:
      assert property (sel_q[4] >= 6'h30 |=> !capture_five_input_o)
      else $error("out of range selector not inactive");
endmodule

bind pps_top pps_top_chk u_chk (
   .core_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
   .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .remappable_io_pin_i,
   .capture_one_input_o, .capture_three_input_o, .capture_five_input_o,
   .compare_fault_a_input_o, .timer_ext_clock_a_o,
   .tamper_detect_input_o, .reference_clock_input_o
);

/* File: tb/pps_tb_top.sv */
// self-checking bench for the input pin select
`timescale 1ns/1ps
`include "pps_regs.svh"

module pps_tb_top;
   import pps_pkg::*;
   // selector words in offset order; pin 47 and the first bad value
   localparam pps_word_t REG_V [6] =
      '{32'h2f00, 32'h0a05, 32'h1514, 32'h1f1e, 32'h2928, 32'h0030};
   // selector each routed input ends up with, in output order
   localparam pps_sel_t SEL_E [11] = '{6'h00, 6'h2f, 6'h05, 6'h0a,
      6'h30, 6'h14, 6'h15, 6'h1e, 6'h1f, 6'h29, 6'h28};
   localparam logic [47:0] PAT = 48'ha5a5_5a5a_c3c3;
   logic           core_clk;
   logic           rst_n;
   logic           hsel;
   logic           hwrite;
   logic [1:0]     htrans;
   pps_word_t      haddr;
   pps_word_t      hwdata;
   wire pps_word_t hrdata;
   wire            hready;
   logic [47:0]    pat;
   wire  [47:0]    pins;
   wire  [10:0]    outs;
   int             error_cnt;
   int             compares;

   pps_pin_model u_pins (.core_clk_i(core_clk), .pat_i(pat),
      .pins_o(pins));
   pps_top uut (
      .core_clk_i(core_clk), .rst_n_i(rst_n), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hreadyout_o(hready), .hresp_o(), .hrdata_o(hrdata),
      .remappable_io_pin_i(pins),
      .capture_one_input_o(outs[0]), .capture_two_input_o(outs[1]),
      .capture_three_input_o(outs[2]), .capture_four_input_o(outs[3]),
      .capture_five_input_o(outs[4]), .compare_fault_a_input_o(outs[5]),
      .compare_fault_b_input_o(outs[6]), .timer_ext_clock_a_o(outs[7]),
      .timer_ext_clock_b_o(outs[8]), .tamper_detect_input_o(outs[9]),
      .reference_clock_input_o(outs[10]));

   function automatic logic [10:0] route(input logic [47:0] p);
      logic [10:0] r;
      for (int k = 0; k < 11; k++)
         r[k] = (SEL_E[k] < 6'h30) ? p[SEL_E[k]] : 1'b0;
      return r;
   endfunction

   task automatic chk(input pps_word_t seen, input pps_word_t exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // entered at a rising edge; returns at the edge ending the data phase
   task automatic xfer(input logic wr, input pps_word_t a,
                       input pps_word_t wd, output pps_word_t q);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= a;
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? wd : 32'h0;
      do @(posedge core_clk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input pps_word_t a, input pps_word_t d);
      pps_word_t q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input pps_word_t a, input pps_word_t e);
      pps_word_t q;
      xfer(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   task automatic out_chk();
      chk({21'h0, outs}, {21'h0, route(pat)});
   endtask

   task automatic end_of_test();
      if (error_cnt == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // the tests need some one hundred ten cycles; this cuts a hang short
   initial begin
      repeat (4000) @(posedge core_clk);
      error_cnt++;
      end_of_test();
   end

   initial begin
      error_cnt = 0;
      compares = 0;
      rst_n <= 1'b0;
      {hsel, hwrite, htrans} <= 4'h0;
      haddr <= 32'h0;
      hwdata <= 32'h0;
      pat <= ~PAT;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      // all ones after reset, so every input sits inactive
      for (int i = 0; i < 6; i++)
         rd_chk(32'(i * 4), i == 5 ? 32'h3f : 32'h3f3f);
      chk({21'h0, outs}, 32'h0);
      // unused bits drop writes, read straight after the write
      for (int i = 0; i < 6; i++) begin
         wr(32'(i * 4), 32'hffff_ffff);
         rd_chk(32'(i * 4), i == 5 ? 32'h3f : 32'h3f3f);
      end
      for (int i = 0; i < 6; i++) begin
         wr(32'(i * 4), REG_V[i]);
         rd_chk(32'(i * 4), REG_V[i]);
      end
      // both levels on every routed input but capture five, which stays inactive
      for (int j = 0; j < 2; j++) begin
         pat <= j ? ~PAT : PAT;
         repeat (3) @(posedge core_clk);
         out_chk();
         wr(`PPS_OFF_STATUS, 32'hffff_ffff);
         rd_chk(`PPS_OFF_STATUS, {21'h0, route(pat)});
      end
      wr(32'h1c, 32'hffff_ffff);
      rd_chk(32'h1c, 32'h0);
      // the new pin shows one cycle after the write, not before
      wr(`PPS_OFF_CAP_LO, 32'h2f02);
      @(posedge core_clk);
      chk({31'h0, outs[0]}, {31'h0, ~PAT[0]});
      @(posedge core_clk);
      chk({31'h0, outs[0]}, {31'h0, ~PAT[2]});
      end_of_test();
   end
endmodule
